// File: design/bfb_boot_fetch.sv
// Purpose: Boot fetch engine, one-line instruction cache, data breakpoint.
// Assumes: Memory holds data stable while ready is low and drops ready
//          once the cycle strobe falls.
// Notes:   Ready is filtered, so each bus cycle is followed by a gap that
//          waits for ready to read high again before the next one opens.
`timescale 1ns/1ps
module bfb_boot_fetch (
  input  logic        sys_clk_i,
  input  logic        rstn_i,
  // Avalon-MM slave.
  input  logic [3:0]  avs_address_i,
  input  logic        avs_read_i,
  input  logic        avs_write_i,
  input  logic [31:0] avs_writedata_i,
  input  logic [3:0]  avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic        avs_waitrequest_o,
  output logic        irq_o,
  // Instruction fetch port from the core.
  input  logic        fetch_req_i,
  input  logic [31:0] fetch_addr_i,
  output logic        fetch_ready_o,
  output logic        fetch_ack_o,
  output logic [31:0] fetch_data_o,
  // Data access and trap instruction reports from the core.
  input  logic        dacc_valid_i,
  input  logic        dacc_write_i,
  input  logic [31:0] dacc_addr_i,
  input  logic        trap_instr_i,
  output logic        trap_o,
  // External bus pins.
  output logic        bus_cycle_o,
  output logic [31:0] bus_addr_o,
  output logic [3:0]  bus_byte_en_n_o,
  output logic        byte_wide_boot_mode_o,
  input  logic [31:0] bus_data_i,
  input  logic        ready_n_i,
  input  logic        int_req_i,
  input  logic        hold_req_i,
  output logic        hold_ack_o
);
  import bfb_pkg::*;

  function automatic logic reg_sel(input logic [3:0] a,
                                   input logic [3:0] ofs);
    reg_sel = (a == ofs);
  endfunction

  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // Pin filtering.
  logic [2:0] pin_raw;
  logic [2:0] pin_f;

  assign pin_raw = {hold_req_i, int_req_i, ready_n_i};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      logic [2:0] sq;
      always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          sq       <= {3{BFB_SYNC_RST[g]}};
          pin_f[g] <= BFB_SYNC_RST[g];
        end else begin
          sq <= {sq[1:0], pin_raw[g]};
          if (sq[1] == sq[2]) begin
            pin_f[g] <= sq[2];
          end
        end
      end
    end
  endgenerate

  // Registers.
  logic [2:0]  ctrl;
  logic [31:0] bkpt_addr;
  logic [3:0]  stat;
  logic [3:0]  mask;
  logic [3:0]  stat_set;
  logic [3:0]  stat_clr;
  logic        acc_rd;
  logic        acc_wr;
  logic        flush_req;
  logic [31:0] wmask;
  logic [31:0] rd_mux;

  assign acc_rd    = avs_read_i && !avs_waitrequest_o;
  assign acc_wr    = avs_write_i && !avs_waitrequest_o;
  assign wmask     = be_mask(avs_byteenable_i);
  assign flush_req = acc_wr && reg_sel(avs_address_i, BFB_OFS_CTRL) &&
                     avs_byteenable_i[0] &&
                     avs_writedata_i[BFB_CTRL_FLUSH];

  always_comb begin
    rd_mux = 32'h00000000;
    if (reg_sel(avs_address_i, BFB_OFS_CTRL)) begin
      rd_mux[2:0] = ctrl;
    end else if (reg_sel(avs_address_i, BFB_OFS_BKPT)) begin
      rd_mux = bkpt_addr;
    end else if (reg_sel(avs_address_i, BFB_OFS_STAT)) begin
      rd_mux[3:0] = stat;
    end else if (reg_sel(avs_address_i, BFB_OFS_MASK)) begin
      rd_mux[3:0] = mask;
    end
  end

  // One wait state per access; the access lands when waitrequest is low.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h00000000;
    end else if (avs_waitrequest_o && (avs_read_i || avs_write_i)) begin
      avs_waitrequest_o <= 1'b0;
      avs_readdata_o    <= avs_read_i ? rd_mux : 32'h00000000;
    end else begin
      avs_waitrequest_o <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl      <= BFB_CTRL_RST;
      bkpt_addr <= BFB_BKPT_RST;
      mask      <= BFB_MASK_RST;
    end else if (acc_wr) begin
      if (reg_sel(avs_address_i, BFB_OFS_CTRL) && avs_byteenable_i[0]) begin
        ctrl <= avs_writedata_i[2:0];
      end
      if (reg_sel(avs_address_i, BFB_OFS_BKPT)) begin
        bkpt_addr <= (bkpt_addr & ~wmask) | (avs_writedata_i & wmask);
      end
      if (reg_sel(avs_address_i, BFB_OFS_MASK) && avs_byteenable_i[0]) begin
        mask <= avs_writedata_i[3:0];
      end
    end
  end

  assign byte_wide_boot_mode_o = ctrl[BFB_CTRL_BYTE];

  // Breakpoint and trap events.
  logic dat_hit;

  bfb_brk_match u_brk (
    .acc_addr_i  (dacc_addr_i),
    .acc_valid_i (dacc_valid_i),
    .acc_write_i (dacc_write_i),
    .bkpt_addr_i (bkpt_addr),
    .brk_rd_en_i (ctrl[BFB_CTRL_BRK_RD]),
    .brk_wr_en_i (ctrl[BFB_CTRL_BRK_WR]),
    .hit_o       (dat_hit)
  );

  // Fetch engine state.
  bfb_state_e  state;
  logic        boot_pend;
  logic        req_pend;
  logic [31:0] req_addr;
  logic [3:0]  fill_pos;
  logic [4:0]  beats_left;
  logic        fill_bytes;
  logic        fill_done;
  logic        cap_en;
  logic        line_hit;
  logic [3:0]  start_pos;
  logic [3:0]  next_pos;
  logic [31:0] line_mem [4];
  logic [27:0] line_tag;
  logic        line_valid;

  assign cap_en    = (state == BFB_CYCLE) && !pin_f[BFB_PIN_READY];
  assign fill_done = (state == BFB_GAP) && pin_f[BFB_PIN_READY] &&
                     (beats_left == 5'h00);
  // The boot flag forces a miss so a stale line cannot skip the boot fetch.
  assign line_hit  = !boot_pend && line_valid &&
                     (line_tag == req_addr[31:4]);
  assign start_pos = {req_addr[3:2], 2'b00};
  // Byte fills walk down from the wanted byte and wrap inside the line.
  assign next_pos  = fill_bytes ? fill_pos - 4'h1 :
                                  fill_pos + BFB_POS_WSTEP;

  always_comb begin
    stat_set              = 4'h0;
    stat_set[BFB_ST_DAT]  = dat_hit;
    stat_set[BFB_ST_IT]   = trap_instr_i;
    stat_set[BFB_ST_INT]  = pin_f[BFB_PIN_INT];
    stat_set[BFB_ST_FILL] = fill_done;
    // Clear only what software was shown, so a late event is not lost.
    stat_clr = (acc_rd && reg_sel(avs_address_i, BFB_OFS_STAT)) ?
               avs_readdata_o[3:0] : 4'h0;
  end

  // A new event in the clearing cycle survives the read.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stat   <= BFB_STAT_RST;
      irq_o  <= 1'b0;
      trap_o <= 1'b0;
    end else begin
      stat   <= (stat & ~stat_clr) | stat_set;
      irq_o  <= |(stat & mask);
      trap_o <= dat_hit || trap_instr_i;
    end
  end

  // Line storage keeps no reset, so contents and valid survive reset.
  always_ff @(posedge sys_clk_i) begin
    if (cap_en) begin
      if (fill_bytes) begin
        line_mem[fill_pos[3:2]][8*fill_pos[1:0] +: 8] <= bus_data_i[7:0];
      end else begin
        line_mem[fill_pos[3:2]] <= bus_data_i;
      end
    end
    if (fill_done) begin
      line_tag   <= req_addr[31:4];
      line_valid <= 1'b1;
    end
    if (flush_req) begin
      line_valid <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state           <= BFB_IDLE;
      boot_pend       <= 1'b1;
      req_pend        <= 1'b1;
      req_addr        <= BFB_BOOT_ADDR;
      fill_pos        <= 4'h0;
      beats_left      <= 5'h00;
      fill_bytes      <= 1'b0;
      fetch_ready_o   <= 1'b0;
      fetch_ack_o     <= 1'b0;
      fetch_data_o    <= 32'h00000000;
      bus_cycle_o     <= 1'b0;
      bus_addr_o      <= 32'h00000000;
      bus_byte_en_n_o <= BFB_BE_ALL_N;
      hold_ack_o      <= 1'b0;
    end else begin
      fetch_ack_o <= 1'b0;
      hold_ack_o  <= (state == BFB_IDLE) && pin_f[BFB_PIN_HOLD];
      if (fetch_req_i && fetch_ready_o) begin
        req_pend      <= 1'b1;
        req_addr      <= {fetch_addr_i[31:2], 2'b00};
        fetch_ready_o <= 1'b0;
      end
      unique case (state)
        BFB_IDLE: begin
          if (req_pend && line_hit) begin
            fetch_ack_o   <= 1'b1;
            fetch_data_o  <= line_mem[req_addr[3:2]];
            req_pend      <= 1'b0;
            fetch_ready_o <= 1'b1;
          end else if (req_pend && !pin_f[BFB_PIN_HOLD]) begin
            state       <= BFB_CYCLE;
            fill_pos    <= start_pos;
            fill_bytes  <= ctrl[BFB_CTRL_BYTE];
            beats_left  <= ctrl[BFB_CTRL_BYTE] ? BFB_BEATS_BYTE :
                                                 BFB_BEATS_WORD;
            bus_cycle_o <= 1'b1;
            bus_addr_o  <= {req_addr[31:4], start_pos[3:2], 2'b00};
            bus_byte_en_n_o <= ctrl[BFB_CTRL_BYTE] ?
                               {BFB_BE_TOP_IDLE, start_pos[1:0]} :
                               BFB_BE_ALL_N;
          end else if (!req_pend && !fetch_ready_o) begin
            fetch_ready_o <= 1'b1;
          end
        end
        BFB_CYCLE: begin
          // With ready never low the cycle stays open and nothing follows.
          if (!pin_f[BFB_PIN_READY]) begin
            state       <= BFB_GAP;
            bus_cycle_o <= 1'b0;
            beats_left  <= beats_left - 5'h01;
            fill_pos    <= next_pos;
          end
        end
        BFB_GAP: begin
          if (pin_f[BFB_PIN_READY]) begin
            if (beats_left == 5'h00) begin
              state     <= BFB_IDLE;
              boot_pend <= 1'b0;
            end else begin
              state       <= BFB_CYCLE;
              bus_cycle_o <= 1'b1;
              bus_addr_o  <= {req_addr[31:4], fill_pos[3:2], 2'b00};
              bus_byte_en_n_o <= fill_bytes ?
                                 {BFB_BE_TOP_IDLE, fill_pos[1:0]} :
                                 BFB_BE_ALL_N;
            end
          end
        end
      endcase
    end
  end

endmodule

// File: design/bfb_pkg.sv
// Purpose: Shared constants and types for the boot fetch and breakpoint block.
// Assumes: One 125 MHz clock, Avalon-MM register slave with 32-bit data.
// Notes:   Byte offsets are word aligned; narrow registers sit in low bits.
package bfb_pkg;

  localparam logic [31:0] BFB_BOOT_ADDR   = 32'hFFFFFF00;

  // Register byte offsets.
  localparam logic [3:0]  BFB_OFS_CTRL    = 4'h0;
  localparam logic [3:0]  BFB_OFS_BKPT    = 4'h4;
  localparam logic [3:0]  BFB_OFS_STAT    = 4'h8;
  localparam logic [3:0]  BFB_OFS_MASK    = 4'hC;

  // Control register fields.
  localparam int          BFB_CTRL_BRK_RD = 0;
  localparam int          BFB_CTRL_BRK_WR = 1;
  localparam int          BFB_CTRL_BYTE   = 2;
  localparam int          BFB_CTRL_FLUSH  = 3;

  // Status and mask register fields.
  localparam int          BFB_ST_DAT      = 0;
  localparam int          BFB_ST_IT       = 1;
  localparam int          BFB_ST_INT      = 2;
  localparam int          BFB_ST_FILL     = 3;

  // Reset values.
  localparam logic [2:0]  BFB_CTRL_RST    = 3'h0;
  localparam logic [31:0] BFB_BKPT_RST    = 32'h00000000;
  localparam logic [3:0]  BFB_STAT_RST    = 4'h0;
  localparam logic [3:0]  BFB_MASK_RST    = 4'h0;

  // Pin synchroniser lanes; ready idles high, the requests idle low.
  localparam int          BFB_PIN_READY   = 0;
  localparam int          BFB_PIN_INT     = 1;
  localparam int          BFB_PIN_HOLD    = 2;
  localparam logic [2:0]  BFB_SYNC_RST    = 3'h1;

  // Line fill beat counts and lane encodings.
  localparam logic [4:0]  BFB_BEATS_WORD  = 5'h04;
  localparam logic [4:0]  BFB_BEATS_BYTE  = 5'h10;
  localparam logic [3:0]  BFB_POS_WSTEP   = 4'h4;
  localparam logic [3:0]  BFB_BE_ALL_N    = 4'h0;
  localparam logic [1:0]  BFB_BE_TOP_IDLE = 2'h3;

  typedef enum logic [1:0] {
    BFB_IDLE,
    BFB_CYCLE,
    BFB_GAP
  } bfb_state_e;

endpackage

// File: design/bfb_brk_match.sv
// Purpose: Data breakpoint compare for one data access.
// Assumes: Access signals come from logic on the same clock.
// Notes:   Purely combinational; the caller registers the outcome.
`timescale 1ns/1ps
module bfb_brk_match (
  input  logic [31:0] acc_addr_i,
  input  logic        acc_valid_i,
  input  logic        acc_write_i,
  input  logic [31:0] bkpt_addr_i,
  input  logic        brk_rd_en_i,
  input  logic        brk_wr_en_i,
  output logic        hit_o
);

  logic addr_eq;
  logic type_en;

  assign addr_eq = (acc_addr_i == bkpt_addr_i);
  assign type_en = acc_write_i ? brk_wr_en_i : brk_rd_en_i;
  assign hit_o   = acc_valid_i && addr_eq && type_en;

endmodule

// File: test/bfb_boot_chk.sv
// Purpose: Port-level checks for the boot fetch and breakpoint block.
// Assumes: Sees only the top module ports; one clock domain.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/1ps
module bfb_boot_chk
  import bfb_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        rstn_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic        avs_waitrequest_o,
  input wire logic        dacc_valid_i,
  input wire logic        trap_instr_i,
  input wire logic        trap_o,
  input wire logic        bus_cycle_o,
  input wire logic [31:0] bus_addr_o,
  input wire logic [3:0]  bus_byte_en_n_o,
  input wire logic        byte_wide_boot_mode_o,
  input wire logic        ready_n_i,
  input wire logic        hold_ack_o,
  input wire logic        fetch_ack_o
);
  logic seen;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      seen <= 1'b0;
    end else if (bus_cycle_o) begin
      seen <= 1'b1;
    end
  end
  boot_addr_a: assert property (bus_cycle_o && !seen |->
    bus_addr_o == BFB_BOOT_ADDR) else $error("first cycle address wrong");
  byte_lane_a: assert property (bus_cycle_o |->
    (byte_wide_boot_mode_o ? bus_byte_en_n_o[3:2] == 2'h3
     : bus_byte_en_n_o == BFB_BE_ALL_N)) else $error("byte lanes wrong");
  wait_state_a: assert property (ready_n_i[*4] ##0 bus_cycle_o |=>
    bus_cycle_o && !fetch_ack_o) else $error("cycle closed without ready");
  addr_stable_a: assert property (bus_cycle_o && $past(bus_cycle_o) |->
    $stable(bus_addr_o) && $stable(bus_byte_en_n_o))
    else $error("address moved in open cycle");
  wait_req_a: assert property ((avs_read_i || avs_write_i) &&
    avs_waitrequest_o |=> !avs_waitrequest_o) else $error("no answer");
  wait_one_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  instr_trap_a: assert property (trap_instr_i |=> trap_o)
    else $error("trap instruction gave no trap");
  trap_cause_a: assert property (trap_o |->
    $past(trap_instr_i || dacc_valid_i)) else $error("trap without cause");
  hold_idle_a: assert property (hold_ack_o |-> !bus_cycle_o)
    else $error("hold granted during bus cycle");
endmodule
bind bfb_boot_fetch bfb_boot_chk i_chk (.sys_clk_i, .rstn_i, .avs_read_i,
  .avs_write_i, .avs_waitrequest_o, .dacc_valid_i, .trap_instr_i, .trap_o,
  .bus_cycle_o, .bus_addr_o, .bus_byte_en_n_o, .byte_wide_boot_mode_o,
  .ready_n_i, .hold_ack_o, .fetch_ack_o);

// File: test/bfb_mem_model.sv
// Purpose: Boot memory with decoder and ready logic on the external bus.
// Assumes: Ready is held low until the cycle strobe falls.
// Notes:   Released data lines invert each cycle so stale data never match.
`timescale 1ns/1ps
module bfb_mem_model (
  input  wire logic        sys_clk_i,
  input  wire logic        bus_cycle_i,
  input  wire logic [31:0] bus_addr_i,
  input  wire logic [3:0]  bus_byte_en_n_i,
  input  wire logic        byte_mode_i,
  input  wire logic        stall_i,
  input  wire logic [1:0]  wait_i,
  output logic      [31:0] bus_data_o,
  output logic             ready_n_o
);
  int cnt = 0;
  initial begin
    ready_n_o  = 1'b1;
    bus_data_o = 32'h0;
  end
  always @(posedge sys_clk_i) begin
    if (bus_cycle_i && ready_n_o) begin
      cnt <= cnt + 1;
      if (!stall_i && cnt >= wait_i) begin
        ready_n_o  <= 1'b0;
        // Byte lanes act as the low ROM address in byte mode.
        bus_data_o <= byte_mode_i ? {24'hC3C3C3, 4'hA, bus_addr_i[3:2],
          bus_byte_en_n_i[1:0]} : ~bus_addr_i;
      end
    end else if (!bus_cycle_i) begin
      ready_n_o  <= 1'b1;
      cnt        <= 0;
      bus_data_o <= ~bus_data_o;
    end
  end
endmodule

// File: test/tb.sv
// Purpose: Self-checking bench for the boot fetch and breakpoint block.
// Assumes: Memory model answers every bus cycle unless stalled.
// Notes:   The stall test is last since it leaves the bus hung.
`timescale 1ns/1ps
module tb;
  import bfb_pkg::*;
  logic        sys_clk_i, rstn_i, avs_read_i, avs_write_i, fetch_req_i;
  logic        dacc_valid_i, dacc_write_i, trap_instr_i, int_req_i;
  logic        hold_req_i, avs_waitrequest_o, irq_o, fetch_ready_o;
  logic        fetch_ack_o, trap_o, bus_cycle_o, mode, ready_n, hold_ack_o;
  logic        m_stall, cyc_d;
  logic [1:0]  m_wait;
  logic [3:0]  avs_address_i, be_n;
  logic [31:0] avs_writedata_i, avs_readdata_o, fetch_addr_i, fetch_data_o;
  logic [31:0] dacc_addr_i, bus_addr_o, bus_data, d;
  logic [31:0] adr_q[$];
  logic [3:0]  be_q[$];
  int          fail_count = 0, tests_run = 0, n;
  bfb_boot_fetch i_dut (.sys_clk_i, .rstn_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i(4'hF),
    .avs_readdata_o, .avs_waitrequest_o, .irq_o, .fetch_req_i, .fetch_addr_i,
    .fetch_ready_o, .fetch_ack_o, .fetch_data_o, .dacc_valid_i, .dacc_write_i,
    .dacc_addr_i, .trap_instr_i, .trap_o, .bus_cycle_o, .bus_addr_o,
    .bus_byte_en_n_o(be_n), .byte_wide_boot_mode_o(mode),
    .bus_data_i(bus_data), .ready_n_i(ready_n), .int_req_i, .hold_req_i,
    .hold_ack_o);
  bfb_mem_model i_mem (.sys_clk_i, .bus_cycle_i(bus_cycle_o),
    .bus_addr_i(bus_addr_o), .bus_byte_en_n_i(be_n), .byte_mode_i(mode),
    .stall_i(m_stall), .wait_i(m_wait), .bus_data_o(bus_data),
    .ready_n_o(ready_n));
  always @(posedge sys_clk_i) begin
    cyc_d <= bus_cycle_o;
    if (bus_cycle_o === 1'b1 && !cyc_d) begin
      adr_q.push_back(bus_addr_o);
      be_q.push_back(be_n);
    end
  end
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] w);
    @(posedge sys_clk_i);
    avs_read_i <= !wr;
    avs_write_i <= wr;
    avs_address_i <= a;
    avs_writedata_i <= w;
    do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'b0);
    d = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic fetch(input logic [31:0] a, input logic [31:0] e,
                       input bit want);
    logic ack = 1'b0;
    @(posedge sys_clk_i);
    fetch_req_i <= 1'b1;
    fetch_addr_i <= a;
    do @(posedge sys_clk_i); while (fetch_ready_o !== 1'b1);
    fetch_req_i <= 1'b0;
    for (int t = 0; t < 1000 && !ack; t++) begin
      @(posedge sys_clk_i);
      ack = fetch_ack_o === 1'b1;
    end
    chk("fetch ack", want, ack);
    if (want) chk("fetch data", e, fetch_data_o);
  endtask
  task automatic pulse(input logic tr, input logic wr, input logic [31:0] a,
                       input logic e);
    logic seen = 1'b0;
    @(posedge sys_clk_i);
    trap_instr_i <= tr;
    dacc_valid_i <= !tr;
    dacc_write_i <= wr;
    dacc_addr_i <= a;
    @(posedge sys_clk_i);
    trap_instr_i <= 1'b0;
    dacc_valid_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i) seen |= trap_o === 1'b1;
    chk("trap", e, seen);
  endtask
  task automatic t_boot();
    fetch(32'hFFFFFF08, 32'h000000F7, 1);
    for (int i = 0; i < 4; i++)
      chk("fill", BFB_BOOT_ADDR + 4 * i, adr_q[i]);
    n = adr_q.size();
    fetch(32'hFFFFFF0C, 32'h000000F3, 1);
    chk("hit cycles", n, adr_q.size());
    bus(1, BFB_OFS_CTRL, 32'h8);
    fetch(32'hFFFFFF04, 32'h000000FB, 1);
    chk("refill", n + 4, adr_q.size());
    bus(0, BFB_OFS_STAT, 0);
    chk("fill done", 32'h8, d);
    $display("test boot done");
  endtask
  task automatic t_byte();
    bus(1, BFB_OFS_CTRL, 32'h4);
    @(posedge sys_clk_i);
    chk("mode", 1, mode);
    m_wait <= 2'h3;
    n = adr_q.size();
    fetch(32'h00000124, 32'hA7A6A5A4, 1);
    chk("beats", n + 16, adr_q.size());
    for (int i = 0; i < 16; i++) chk("byte pos", {28'h12, 4'(4 - i)},
      {adr_q[n + i][31:2], be_q[n + i][1:0]});
    bus(0, BFB_OFS_STAT, 0);
    chk("byte fill done", 32'h8, d);
    bus(1, BFB_OFS_CTRL, 0);
    @(posedge sys_clk_i);
    chk("mode off", 0, mode);
    $display("test byte done");
  endtask
  task automatic t_brk();
    bus(1, BFB_OFS_BKPT, 32'h400);
    for (int k = 0; k < 8; k++) begin
      bus(1, BFB_OFS_CTRL, k[2] ? 32'h2 : 32'h1);
      pulse(0, k[0], k[1] ? 32'h400 : 32'h404, k[1] && k[0] == k[2]);
    end
    bus(0, BFB_OFS_STAT, 0);
    chk("data trap flag", 32'h1, d);
    pulse(1, 0, 0, 1);
    bus(1, BFB_OFS_MASK, 32'h2);
    repeat (2) @(posedge sys_clk_i);
    chk("irq", 1, irq_o);
    bus(0, BFB_OFS_STAT, 0);
    chk("instr trap flag", 32'h2, d);
    repeat (3) @(posedge sys_clk_i);
    chk("irq clear", 0, irq_o);
    $display("test breakpoint done");
  endtask
  task automatic t_pins();
    int_req_i <= 1'b1;
    hold_req_i <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    chk("hold ack", 1, hold_ack_o);
    int_req_i <= 1'b0;
    hold_req_i <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    chk("hold off", 0, hold_ack_o);
    bus(0, BFB_OFS_STAT, 0);
    chk("int seen", 32'h4, d);
    bus(0, 4'h2, 0);
    chk("unmapped", 0, d);
    bus(0, BFB_OFS_MASK, 0);
    chk("mask", 32'h2, d);
    $display("test pins done");
  endtask
  task automatic t_stall();
    m_stall <= 1'b1;
    n = adr_q.size();
    fetch(32'h00000300, 0, 0);
    chk("open cycle", 1, bus_cycle_o);
    chk("no new cycle", n + 1, adr_q.size());
    $display("test stall done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    sys_clk_i = 0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    #200000;
    fail_count++;
    complete_run();
  end
  initial begin
    {rstn_i, avs_read_i, avs_write_i, fetch_req_i, dacc_valid_i} = 0;
    {dacc_write_i, trap_instr_i, int_req_i, hold_req_i, m_stall} = 0;
    {avs_address_i, avs_writedata_i, fetch_addr_i, dacc_addr_i} = 0;
    m_wait = 0;
    cyc_d = 0;
    repeat (20) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    t_boot();
    t_byte();
    t_brk();
    t_pins();
    t_stall();
    complete_run();
  end
endmodule
